// *** rtl/pesms_pkg.sv ***
// shared constants for the event status, mask and sense register group
package pesms_pkg;

  // -----------------------------------------------------------------
  // clock and timing
  // -----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 8.0;
  localparam real OC_DBNC_MS    = 8.0;    // regulator overcurrent debounce
  localparam real OV_DBNC_MS    = 0.122;  // front-end overvoltage debounce
  localparam int  OC_DBNC_CYC   = int'($ceil(OC_DBNC_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  OV_DBNC_CYC   = int'($ceil(OV_DBNC_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [1:0] STRAP_WAIT = 2'h2;  // cycles after release before strap look

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_THERMAL_SENSE = 8'h07;
  localparam logic [7:0] ADDR_BUCK_FAULT_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_BUCK_FAULT_MASK     = 8'h09;
  localparam logic [7:0] ADDR_BUCK_FAULT_SENSE    = 8'h0a;
  localparam logic [7:0] ADDR_BOOST_FUSE_STATUS   = 8'h0e;
  localparam logic [7:0] ADDR_BOOST_FUSE_MASK     = 8'h0f;
  localparam logic [7:0] ADDR_BOOST_FUSE_SENSE    = 8'h10;
  localparam logic [7:0] ADDR_LDO_FAULT_STATUS    = 8'h11;
  localparam logic [7:0] ADDR_LDO_FAULT_MASK      = 8'h12;
  localparam logic [7:0] ADDR_LDO_FAULT_SENSE     = 8'h13;

  // -----------------------------------------------------------------
  // implemented bits and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] BUCK_BITS     = 8'h1b;  // bits 0,1,3,4
  localparam logic [7:0] BOOST_BITS    = 8'hc5;  // bits 0,2,6,7
  localparam logic [7:0] LDO_BITS      = 8'h3f;  // bits 0..5
  localparam logic [7:0] BUCK_MASK_RST = 8'h7f;
  localparam logic [7:0] BOOST_MASK_RST = 8'hc5;
  localparam logic [7:0] LDO_MASK_RST  = 8'h3f;
  localparam logic [7:0] STATUS_RST    = 8'h00;

  // boost/fuse field positions
  localparam int BF_BOOST = 0;
  localparam int BF_OVV   = 2;
  localparam int BF_BLOW  = 6;
  localparam int BF_ECC   = 7;

  // -----------------------------------------------------------------
  // positions inside the synchronised input vector
  // -----------------------------------------------------------------
  localparam int IN_BUTTON  = 0;
  localparam int IN_LOWVIN  = 1;
  localparam int IN_TEMP    = 2;   // four bits, 2..5
  localparam int IN_TEST    = 6;
  localparam int IN_FUSESUP = 7;
  localparam int IN_OC      = 8;   // eleven bits: buck a,b,2,3, boost, ldo x6
  localparam int IN_OVV     = 19;
  localparam int IN_ECC     = 20;
  localparam int IN_BLOW    = 21;
  localparam int IN_VPWRGND = 22;
  localparam int IN_W       = 23;
  localparam int OC_N       = 11;
  localparam int OC_BOOST   = 4;
  localparam int OC_LDO     = 5;

endpackage : pesms_pkg

// *** rtl/pesms_event_regs.sv ***
// event status, mask and live sense registers with active-low interrupt output
`timescale 1ns/100ps

module pesms_event_regs
  import pesms_pkg::*;
#(
  parameter int OC_DBNC = OC_DBNC_CYC,
  parameter int OV_DBNC = OV_DBNC_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // register access from the serial interface engine
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // detector and pin levels, asynchronous
  input  wire logic       power_button_pin_i,
  input  wire logic       input_supply_low_i,
  input  wire logic [3:0] temp_above_i,
  input  wire logic       test_mode_pin_i,
  input  wire logic       fuse_supply_pin_i,
  input  wire logic [3:0] buck_oc_i,
  input  wire logic       boost_oc_i,
  input  wire logic [5:0] ldo_oc_i,
  input  wire logic       overvolt_i,
  input  wire logic       fuse_error_i,
  input  wire logic       fuse_blow_busy_i,
  input  wire logic       front_end_supply_gnd_i,
  // interrupt to host
  output logic            irq_out_n_o
);

  localparam int CW = $clog2(OC_DBNC + 1);
  localparam int VW = $clog2(OV_DBNC + 1);
  localparam logic [CW-1:0] OC_TOP = CW'(OC_DBNC - 1);
  localparam logic [VW-1:0] OV_TOP = VW'(OV_DBNC - 1);

  // -----------------------------------------------------------------
  // timing and usage notes
  // -----------------------------------------------------------------
  // register port
  //   the serial engine raises one strobe for one cycle per access
  //   a read strobe at edge c shows its byte on reg_rdata_o after c
  //   the read byte then stands until the next read strobe
  //   a write and a read in one cycle both act; the read sees old data
  //   writes to sense offsets and to unmapped offsets are dropped
  //   unmapped reads return zero so a stray host read is harmless
  //
  // pin and detector levels
  //   every level crosses two flops before anything reads it
  //   so a sense byte lags its pin by two cycles
  //   a host polling faster than that may see the old level once
  //   sense bytes are never latched, the host sees live state only
  //
  // overcurrent debounce
  //   each channel has its own counter, cleared whenever its level drops
  //   the status bit sets only after OC_DBNC high samples in a row
  //   a level that stays high sets the bit once; a new event needs a drop
  //   counters are wide enough for the full default period
  //   the trade is area: eleven counters rather than one shared timer
  //
  // overvoltage
  //   uses the same scheme with its own shorter period OV_DBNC
  //   the strap is looked at once, after the synchroniser has filled
  //   a grounded front-end supply then sets the flag like an event
  //   the strap pin is not watched again until the next reset
  //
  // fuse events
  //   fuse error sets on the rising edge of its synchronised level
  //   auto-blow done sets on the falling edge of the busy level
  //   neither has a debounce, both come from logic on the die
  //
  // status and mask
  //   status bits are write-one-to-clear; a same-cycle event wins
  //   unused status bits read zero and ignore writes
  //   unused mask bits keep their reset value and ignore writes
  //   all masks come up set, so the interrupt starts quiet
  //
  // interrupt
  //   built from the next status and mask values, then registered
  //   so an unmask or a clear acts on the edge of its own write
  //   the pin stays low while any set status bit is unmasked
  //   reset releases the pin high, masks back at their defaults

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [IN_W-1:0]          sync1;
    logic [IN_W-1:0]          sync2;
    logic [OC_N-1:0][CW-1:0]  oc_cnt;
    logic [OC_N-1:0]          oc_dbn;
    logic [VW-1:0]            ov_cnt;
    logic                     ov_dbn;
    logic                     blow_prev;
    logic                     ecc_prev;
    logic [1:0]               init_cnt;
    logic                     init_done;
    logic [7:0]               buck_stat;
    logic [7:0]               buck_mask;
    logic [7:0]               bf_stat;
    logic [7:0]               bf_mask;
    logic [7:0]               ldo_stat;
    logic [7:0]               ldo_mask;
    logic [7:0]               rdata;
    logic                     irq_n;
  } pesms_state_t;

  localparam pesms_state_t ST_RST = '{
    sync1:     '0,
    sync2:     '0,
    oc_cnt:    '0,
    oc_dbn:    '0,
    ov_cnt:    '0,
    ov_dbn:    1'b0,
    blow_prev: 1'b0,
    ecc_prev:  1'b0,
    init_cnt:  2'h0,
    init_done: 1'b0,
    buck_stat: STATUS_RST,
    buck_mask: BUCK_MASK_RST,
    bf_stat:   STATUS_RST,
    bf_mask:   BOOST_MASK_RST,
    ldo_stat:  STATUS_RST,
    ldo_mask:  LDO_MASK_RST,
    rdata:     8'h00,
    irq_n:     1'b1
  };

  pesms_state_t st_r;
  pesms_state_t st_nxt;

  logic [IN_W-1:0] raw_in;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // write-one-to-clear with the hardware set winning over the clear
  function automatic logic [7:0] pesms_w1c(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic       hit,
                                           input logic [7:0] wd,
                                           input logic [7:0] valid);
    logic [7:0] clr;
    clr = hit ? wd : 8'h00;
    return ((cur & ~clr) | set) & valid;
  endfunction : pesms_w1c

  // writable mask bits take the write, fixed bits keep their default
  function automatic logic [7:0] pesms_mask_wr(input logic [7:0] cur,
                                               input logic       hit,
                                               input logic [7:0] wd,
                                               input logic [7:0] valid);
    return hit ? ((wd & valid) | (cur & ~valid)) : cur;
  endfunction : pesms_mask_wr

  // live sense bytes, built from the second synchroniser stage
  function automatic logic [7:0] pesms_sense(input logic [IN_W-1:0] s,
                                             input logic [7:0]      addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_POWER_THERMAL_SENSE: begin
        v = {s[IN_FUSESUP], s[IN_TEST], s[IN_TEMP+3:IN_TEMP],
             s[IN_LOWVIN], s[IN_BUTTON]};
      end
      ADDR_BUCK_FAULT_SENSE: begin
        v = {3'h0, s[IN_OC+3], s[IN_OC+2], s[IN_OC+1], 1'b0, s[IN_OC]};
      end
      ADDR_BOOST_FUSE_SENSE: begin
        v = {s[IN_ECC], s[IN_BLOW], 3'h0, s[IN_OVV], 1'b0,
             s[IN_OC+OC_BOOST]};
      end
      ADDR_LDO_FAULT_SENSE: begin
        v = {2'h0, s[IN_OC+OC_LDO+5:IN_OC+OC_LDO]};
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : pesms_sense

  // gather asynchronous inputs into one vector for synchronising
  assign raw_in = {front_end_supply_gnd_i, fuse_blow_busy_i, fuse_error_i, overvolt_i,
                   ldo_oc_i, boost_oc_i, buck_oc_i, fuse_supply_pin_i, test_mode_pin_i,
                   temp_above_i, input_supply_low_i, power_button_pin_i};

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:0]      buck_set;
    logic [7:0]      bf_set;
    logic [7:0]      ldo_set;
    logic [OC_N-1:0] oc_rise;
    logic            ov_rise;
    logic            strap_ovv;
    logic            wr_ok;
    buck_set  = 8'h00;
    bf_set    = 8'h00;
    ldo_set   = 8'h00;
    oc_rise   = '0;
    ov_rise   = 1'b0;
    strap_ovv = 1'b0;
    wr_ok     = reg_wr_i;
    st_nxt    = st_r;

    // two-stage synchroniser, only stage two is read below
    st_nxt.sync1 = raw_in;
    st_nxt.sync2 = st_r.sync1;

    // overcurrent debounce: the level must hold the full period
    for (int i = 0; i < OC_N; i++) begin
      if (!st_r.sync2[IN_OC+i]) begin
        st_nxt.oc_cnt[i] = '0;
        st_nxt.oc_dbn[i] = 1'b0;
      end else if (st_r.oc_cnt[i] == OC_TOP) begin
        st_nxt.oc_dbn[i] = 1'b1;
      end else begin
        st_nxt.oc_cnt[i] = st_r.oc_cnt[i] + CW'(1);
      end
      oc_rise[i] = st_nxt.oc_dbn[i] & ~st_r.oc_dbn[i];
    end

    // overvoltage has its own, shorter debounce
    if (!st_r.sync2[IN_OVV]) begin
      st_nxt.ov_cnt = '0;
      st_nxt.ov_dbn = 1'b0;
    end else if (st_r.ov_cnt == OV_TOP) begin
      st_nxt.ov_dbn = 1'b1;
    end else begin
      st_nxt.ov_cnt = st_r.ov_cnt + VW'(1);
    end
    ov_rise = st_nxt.ov_dbn & ~st_r.ov_dbn;

    // strap caught once, after the synchroniser has filled
    if (!st_r.init_done) begin
      if (st_r.init_cnt == STRAP_WAIT) begin
        st_nxt.init_done = 1'b1;
        strap_ovv        = st_r.sync2[IN_VPWRGND];
      end else begin
        st_nxt.init_cnt = st_r.init_cnt + 2'h1;
      end
    end

    // edge trackers for fuse events
    st_nxt.blow_prev = st_r.sync2[IN_BLOW];
    st_nxt.ecc_prev  = st_r.sync2[IN_ECC];

    // set vectors in register bit order
    buck_set = {3'h0, oc_rise[3], oc_rise[2], 1'b0, oc_rise[1], oc_rise[0]};
    bf_set[BF_BOOST] = oc_rise[OC_BOOST];
    bf_set[BF_OVV]   = ov_rise | strap_ovv;
    bf_set[BF_BLOW]  = st_r.blow_prev & ~st_r.sync2[IN_BLOW];
    bf_set[BF_ECC]   = st_r.sync2[IN_ECC] & ~st_r.ecc_prev;
    ldo_set = {2'h0, oc_rise[OC_LDO+5:OC_LDO]};

    // status registers: latched, cleared by writing ones
    st_nxt.buck_stat = pesms_w1c(st_r.buck_stat, buck_set,
                                 wr_ok && reg_addr_i == ADDR_BUCK_FAULT_STATUS,
                                 reg_wdata_i, BUCK_BITS);
    st_nxt.bf_stat   = pesms_w1c(st_r.bf_stat, bf_set,
                                 wr_ok && reg_addr_i == ADDR_BOOST_FUSE_STATUS,
                                 reg_wdata_i, BOOST_BITS);
    st_nxt.ldo_stat  = pesms_w1c(st_r.ldo_stat, ldo_set,
                                 wr_ok && reg_addr_i == ADDR_LDO_FAULT_STATUS,
                                 reg_wdata_i, LDO_BITS);

    // mask registers: only implemented bits are writable
    st_nxt.buck_mask = pesms_mask_wr(st_r.buck_mask,
                                     wr_ok && reg_addr_i == ADDR_BUCK_FAULT_MASK,
                                     reg_wdata_i, BUCK_BITS);
    st_nxt.bf_mask   = pesms_mask_wr(st_r.bf_mask,
                                     wr_ok && reg_addr_i == ADDR_BOOST_FUSE_MASK,
                                     reg_wdata_i, BOOST_BITS);
    st_nxt.ldo_mask  = pesms_mask_wr(st_r.ldo_mask,
                                     wr_ok && reg_addr_i == ADDR_LDO_FAULT_MASK,
                                     reg_wdata_i, LDO_BITS);

    // read data, registered; unmapped offsets read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_BUCK_FAULT_STATUS: st_nxt.rdata = st_r.buck_stat;
        ADDR_BUCK_FAULT_MASK:   st_nxt.rdata = st_r.buck_mask;
        ADDR_BOOST_FUSE_STATUS: st_nxt.rdata = st_r.bf_stat;
        ADDR_BOOST_FUSE_MASK:   st_nxt.rdata = st_r.bf_mask;
        ADDR_LDO_FAULT_STATUS:  st_nxt.rdata = st_r.ldo_stat;
        ADDR_LDO_FAULT_MASK:    st_nxt.rdata = st_r.ldo_mask;
        default:                st_nxt.rdata = pesms_sense(st_r.sync2, reg_addr_i);
      endcase
    end

    // interrupt from next status and mask so unmasking acts at once
    st_nxt.irq_n = ~(|(st_nxt.buck_stat & ~st_nxt.buck_mask) |
                     |(st_nxt.bf_stat   & ~st_nxt.bf_mask)   |
                     |(st_nxt.ldo_stat  & ~st_nxt.ldo_mask));
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state flops
  assign reg_rdata_o = st_r.rdata;
  assign irq_out_n_o = st_r.irq_n;

endmodule : pesms_event_regs

// *** bench/pesms_event_regs_properties.sv ***
// port-level assertions for the event status, mask and sense register group
`timescale 1ns/100ps
module pesms_event_regs_properties #(
  parameter int OC_DBNC = 4,
  parameter int OV_DBNC = 3
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       power_button_pin_i,
  input wire logic       input_supply_low_i,
  input wire logic [3:0] temp_above_i,
  input wire logic       test_mode_pin_i,
  input wire logic       fuse_supply_pin_i,
  input wire logic [3:0] buck_oc_i,
  input wire logic       boost_oc_i,
  input wire logic [5:0] ldo_oc_i,
  input wire logic       overvolt_i,
  input wire logic       fuse_error_i,
  input wire logic       fuse_blow_busy_i,
  input wire logic       front_end_supply_gnd_i,
  input wire logic       irq_out_n_o
);
  logic [7:0]  pins_v;
  logic [21:0] live_v;
  logic        unmask_seen_r;
  // sense reads lag the pins by two flops, so they are judged only after a steady spell
  assign pins_v = {fuse_supply_pin_i, test_mode_pin_i, temp_above_i, input_supply_low_i,
                   power_button_pin_i};
  assign live_v = {pins_v, buck_oc_i, boost_oc_i, ldo_oc_i, overvolt_i, fuse_error_i,
                   fuse_blow_busy_i};
  // set once any mask write may have opened the interrupt path
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unmask_seen_r <= 1'b0;
    end else if (reg_wr_i && reg_wdata_i != 8'hff &&
                 reg_addr_i inside {8'h09, 8'h0f, 8'h12}) begin
      unmask_seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_steady_rd(logic [7:0] a);
    $stable(live_v)[*2] ##0 s_rd(a);
  endsequence
  AST_PIN_SENSE:
    assert property (s_steady_rd(8'h07) |=> reg_rdata_o == $past(pins_v)) else $error("pin sense");
  AST_BUCK_SENSE:
    assert property (s_steady_rd(8'h0a) |=> reg_rdata_o ==
      {3'h0, $past(buck_oc_i[3:1]), 1'b0, $past(buck_oc_i[0])}) else $error("buck sense");
  AST_BOOST_SENSE:
    assert property (s_steady_rd(8'h10) |=> reg_rdata_o == {$past(fuse_error_i),
      $past(fuse_blow_busy_i), 3'h0, $past(overvolt_i), 1'b0, $past(boost_oc_i)})
      else $error("boost sense");
  AST_LDO_SENSE:
    assert property (s_steady_rd(8'h13) |=> reg_rdata_o == {2'h0, $past(ldo_oc_i)})
      else $error("ldo sense");
  AST_BUCK_MASK_FIXED:
    assert property (s_rd(8'h09) |=> (reg_rdata_o & 8'he4) == 8'h64) else $error("buck mask");
  AST_BUCK_STAT_UNUSED:
    assert property (s_rd(8'h08) |=> (reg_rdata_o & 8'he4) == 8'h00) else $error("buck stat");
  AST_BF_UNUSED:
    assert property ((s_rd(8'h0e) or s_rd(8'h0f)) |=> (reg_rdata_o & 8'h3a) == 8'h00)
      else $error("boost unused");
  AST_LDO_UNUSED:
    assert property ((s_rd(8'h11) or s_rd(8'h12)) |=> reg_rdata_o[7:6] == 2'h0)
      else $error("ldo unused");
  AST_UNMAPPED:
    assert property (reg_rd_i && !(reg_addr_i inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e,
      8'h0f, 8'h10, 8'h11, 8'h12, 8'h13}) |=> reg_rdata_o == 8'h00) else $error("unmapped");
  AST_IRQ_MASKED:
    assert property (!unmask_seen_r |-> irq_out_n_o) else $error("irq while masked");
endmodule : pesms_event_regs_properties
bind pesms_event_regs pesms_event_regs_properties #(.OC_DBNC(OC_DBNC), .OV_DBNC(OV_DBNC)) u_props (
  .clk_sys_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .power_button_pin_i, .input_supply_low_i, .temp_above_i, .test_mode_pin_i,
  .fuse_supply_pin_i, .buck_oc_i, .boost_oc_i, .ldo_oc_i, .overvolt_i, .fuse_error_i,
  .fuse_blow_busy_i, .front_end_supply_gnd_i, .irq_out_n_o);

// *** bench/pesms_host_model.sv ***
// host model: single byte reads and writes on the register strobe port
`timescale 1ns/100ps
module pesms_host_model (
  input  wire logic       clk_sys_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one transfer; released lines flip so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_sys_i);
    #1;
    reg_wr_o    = w;
    reg_rd_o    = !w;
    reg_addr_o  = a;
    reg_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
    q           = reg_rdata_i;
  endtask : xfer
endmodule : pesms_host_model

// *** bench/pesms_event_regs_tb_top.sv ***
// self-checking bench for the event status, mask and sense register group
`timescale 1ns/100ps
module pesms_event_regs_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        wr, rd, irq_n, ovv = 1'b0, ecc = 1'b0, busy = 1'b0;
  logic [7:0]  addr, wdata, rdata, pins_v = 8'h00;
  logic [10:0] oc_v = 11'h000;
  logic        strap = 1'b1;
  logic [31:0] lfsr = 32'h62f9fae0;
  logic [7:0]  wa [5] = '{8'h09, 8'h0f, 8'h12, 8'h0a, 8'h0b};
  logic [7:0]  we [5] = '{8'h7f, 8'hc5, 8'h3f, 8'h00, 8'h00};
  logic [7:0]  wz [3] = '{8'h64, 8'h00, 8'h00};
  int          n_fail = 0;
  int          comparisons = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  pesms_event_regs #(.OC_DBNC(4), .OV_DBNC(3)) dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .power_button_pin_i(pins_v[0]), .input_supply_low_i(pins_v[1]),
    .temp_above_i(pins_v[5:2]), .test_mode_pin_i(pins_v[6]), .fuse_supply_pin_i(pins_v[7]),
    .buck_oc_i(oc_v[3:0]), .boost_oc_i(oc_v[4]), .ldo_oc_i(oc_v[10:5]),
    .overvolt_i(ovv), .fuse_error_i(ecc), .fuse_blow_busy_i(busy),
    .front_end_supply_gnd_i(strap), .irq_out_n_o(irq_n));
  pesms_host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), q, exp);
  endtask : rc
  task automatic irq(input logic exp);
    check("irq", {7'h00, irq_n}, {7'h00, exp});
  endtask : irq
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // status offset, status bit and sense bit of overcurrent channel i
  function automatic logic [23:0] oc_loc(input int i);
    if (i < 4) return {8'h08, 8'h01 << (i + (i > 1)), 8'h01 << (i + (i > 0))};
    if (i == 4) return {8'h0e, 8'h01, 8'h01};
    return {8'h11, 8'h01 << (i - 5), 8'h01 << (i - 5)};
  endfunction : oc_loc
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    n_fail++;
    close_out();
  end
  initial begin
    logic [23:0] loc;
    cyc(16);
    rst_b_i = 1'b1;
    cyc(4);
    irq(1'b1);
    rc(8'h08, 8'h00);
    rc(8'h11, 8'h00);
    rc(8'h0e, 8'h04);
    w(8'h0e, 8'h04);
    rc(8'h0e, 8'h00);
    // defaults, fixed bits and read-only places shrug off writes
    for (int k = 0; k < 5; k++) begin
      rc(wa[k], we[k]);
      w(wa[k], 8'hff);
      rc(wa[k], we[k]);
    end
    for (int k = 0; k < 3; k++) begin
      w(wa[k], 8'h00);
      rc(wa[k], wz[k]);
    end
    // each overcurrent: short glitch refused, long one latched, then cleared
    for (int i = 0; i < 11; i++) begin
      loc = oc_loc(i);
      oc_v[i] = 1'b1;
      cyc(3);
      oc_v[i] = 1'b0;
      cyc(6);
      rc(loc[23:16], 8'h00);
      oc_v[i] = 1'b1;
      cyc(8);
      irq(1'b0);
      rc(loc[23:16] + 8'h02, loc[7:0]);
      oc_v[i] = 1'b0;
      cyc(4);
      rc(loc[23:16] + 8'h02, 8'h00);
      w(loc[23:16], ~loc[15:8]);
      rc(loc[23:16], loc[15:8]);
      w(loc[23:16], loc[15:8]);
      cyc(1);
      irq(1'b1);
    end
    // masked event stays quiet until its mask opens
    w(8'h09, 8'hff);
    oc_v[0] = 1'b1;
    cyc(8);
    oc_v[0] = 1'b0;
    irq(1'b1);
    w(8'h09, 8'h7e);
    cyc(1);
    irq(1'b0);
    w(8'h08, 8'h01);
    cyc(1);
    irq(1'b1);
    // fuse programming, fuse error and overvoltage
    busy = 1'b1;
    cyc(4);
    rc(8'h10, 8'h40);
    rc(8'h0e, 8'h00);
    busy = 1'b0;
    cyc(4);
    rc(8'h0e, 8'h40);
    ecc = 1'b1;
    ovv = 1'b1;
    cyc(8);
    rc(8'h10, 8'h84);
    rc(8'h0e, 8'hc4);
    ecc = 1'b0;
    ovv = 1'b0;
    cyc(4);
    w(8'h0e, 8'hff);
    cyc(1);
    irq(1'b1);
    rc(8'h0e, 8'h00);
    // second reset with the strap open: no overvoltage flag, defaults back
    strap = 1'b0;
    rst_b_i = 1'b0;
    cyc(2);
    rst_b_i = 1'b1;
    cyc(4);
    irq(1'b1);
    rc(8'h0e, 8'h00);
    rc(8'h09, 8'h7f);
    rc(8'h0f, 8'hc5);
    // random pin levels and mask values
    for (int n = 0; n < 24; n++) begin
      lfsr = lfsr_next(lfsr);
      pins_v = lfsr[7:0];
      cyc(3);
      rc(8'h07, pins_v);
      w(8'h12, lfsr[15:8]);
      rc(8'h12, lfsr[15:8] & 8'h3f);
    end
    close_out();
  end
endmodule : pesms_event_regs_tb_top
